// >>> hdl/ata_host_channel_port.sv
// Purpose: host end of a two-connector disk channel, normal and sync DMA
// Assumes: pins synchronised here; pos_in and user side on ref_clk_in
// Notes: one transfer at a time, on the connector picked by req_chan_in

`timescale 1ns/100ps

module ata_host_channel_port (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic pos_in,
    input wire logic single_chan_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [2:0] req_kind_in,
    input wire logic req_chan_in,
    input wire logic req_ctl_blk_in,
    input wire logic [ata_port_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [ata_port_pkg::DATA_W-1:0] req_wdata_in,
    input wire logic udma_stop_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [ata_port_pkg::DATA_W-1:0] rd_data_out,
    output logic busy_out,
    output logic [ata_port_pkg::ADDR_W-1:0] pri_reg_addr_out,
    output logic pri_reg_addr_oe_out,
    output logic pri_cmd_block_sel_n_out,
    output logic pri_ctl_block_sel_n_out,
    input wire logic [ata_port_pkg::DATA_W-1:0] pri_disk_data_in,
    output logic [ata_port_pkg::DATA_W-1:0] pri_disk_data_out,
    output logic pri_disk_data_oe_out,
    output logic pri_dma_ack_n_out,
    input wire logic pri_dma_req_in,
    output logic pri_read_strobe_n_out,
    output logic pri_write_strobe_n_out,
    output logic pri_write_strobe_oe_out,
    input wire logic pri_chan_ready_in,
    output logic [ata_port_pkg::ADDR_W-1:0] sec_reg_addr_out,
    output logic sec_reg_addr_oe_out,
    output logic sec_cmd_block_sel_n_out,
    output logic sec_ctl_block_sel_n_out,
    output logic sec_ctl_block_sel_oe_out,
    input wire logic [ata_port_pkg::DATA_W-1:0] sec_disk_data_in,
    output logic [ata_port_pkg::DATA_W-1:0] sec_disk_data_out,
    output logic sec_disk_data_oe_out,
    output logic sec_dma_ack_n_out,
    input wire logic sec_dma_req_in,
    output logic sec_read_strobe_n_out,
    output logic sec_write_strobe_n_out,
    input wire logic sec_chan_ready_in
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic rst_s1;
    logic rst_n;
    ata_port_pkg::state_t state;
    ata_port_pkg::kind_t kind;
    logic [3:0] cnt;
    logic chan;
    logic rd_n;
    logic wr_n;
    logic cmd_n;
    logic ctl_n;
    logic ack_n;
    logic doe;
    logic addr_oe;
    logic pend;
    logic push;
    logic [ata_port_pkg::DATA_W-1:0] dout;
    logic [ata_port_pkg::DATA_W-1:0] push_data;
    logic [ata_port_pkg::ADDR_W-1:0] addr_q [ata_port_pkg::NCHAN];
    logic [ata_port_pkg::DATA_W-1:0] data_pin [ata_port_pkg::NCHAN];
    logic [ata_port_pkg::DATA_W-1:0] data_s1 [ata_port_pkg::NCHAN];
    logic [ata_port_pkg::DATA_W-1:0] data_s2 [ata_port_pkg::NCHAN];
    logic [ata_port_pkg::NCHAN-1:0] req_pin;
    logic [ata_port_pkg::NCHAN-1:0] rdy_pin;
    logic [ata_port_pkg::NCHAN-1:0] req_s1;
    logic [ata_port_pkg::NCHAN-1:0] req_s2;
    logic [ata_port_pkg::NCHAN-1:0] rdy_s1;
    logic [ata_port_pkg::NCHAN-1:0] rdy_s2;
    logic [ata_port_pkg::NCHAN-1:0] rdy_s3;
    logic dreq;
    logic rdy;
    logic rdy_edge;
    logic [ata_port_pkg::DATA_W-1:0] din;
    logic buf_in_ready;
    logic take;
    logic is_wr;
    logic is_dma;
    logic st_idle;
    logic st_strobe;
    logic st_ud_rd;
    logic st_ud_wr;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers, one set per connector
    // ----------------------------------------------------------------
    assign data_pin[0] = pri_disk_data_in;
    assign data_pin[1] = sec_disk_data_in;
    assign req_pin = {sec_dma_req_in, pri_dma_req_in};
    assign rdy_pin = {sec_chan_ready_in, pri_chan_ready_in};

    genvar c;
    generate
        for (c = 0; c < ata_port_pkg::NCHAN; c = c + 1) begin : g_chan
            always_ff @(posedge ref_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    data_s1[c] <= ata_port_pkg::DATA_ZERO;
                    data_s2[c] <= ata_port_pkg::DATA_ZERO;
                    req_s1[c] <= 1'b0;
                    req_s2[c] <= 1'b0;
                    rdy_s1[c] <= 1'b0;
                    rdy_s2[c] <= 1'b0;
                    rdy_s3[c] <= 1'b0;
                end else if (ce_in) begin
                    data_s1[c] <= data_pin[c];
                    data_s2[c] <= data_s1[c];
                    req_s1[c] <= req_pin[c];
                    req_s2[c] <= req_s1[c];
                    rdy_s1[c] <= rdy_pin[c];
                    rdy_s2[c] <= rdy_s1[c];
                    rdy_s3[c] <= rdy_s2[c];
                end
            end

            // Each connector takes the address only when picked by req_chan_in, or always with single_chan_in
            always_ff @(posedge ref_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    addr_q[c] <= ata_port_pkg::ADDR_ZERO;
                end else if (ce_in && take && (req_chan_in == 1'(c) || single_chan_in)) begin
                    addr_q[c] <= req_addr_in;
                end
            end
        end
    endgenerate

    assign dreq = req_s2[chan];
    assign rdy = rdy_s2[chan];
    assign rdy_edge = rdy_s2[chan] ^ rdy_s3[chan];
    assign din = data_s2[chan];

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    assign st_idle = (state == ata_port_pkg::ST_IDLE);
    assign st_strobe = (state == ata_port_pkg::ST_STROBE);
    assign st_ud_rd = (state == ata_port_pkg::ST_UD_RD);
    assign st_ud_wr = (state == ata_port_pkg::ST_UD_WR);
    assign is_wr = (kind == ata_port_pkg::KIND_REG_WR) || (kind == ata_port_pkg::KIND_DMA_WR);
    assign is_dma = (kind == ata_port_pkg::KIND_DMA_RD) || (kind == ata_port_pkg::KIND_DMA_WR);
    // Sync write words only while the drive holds its ready low
    assign req_ready_out = ce_in && ((st_idle && buf_in_ready)
        || (st_ud_wr && !pend && !rdy && !udma_stop_in));
    assign take = req_valid_in && req_ready_out && st_idle;
    assign busy_out = !st_idle;

    // ----------------------------------------------------------------
    // Transfer engine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ata_port_pkg::ST_IDLE;
            kind <= ata_port_pkg::KIND_REG_RD;
            cnt <= ata_port_pkg::CNT_ZERO;
            chan <= 1'b0;
            rd_n <= ata_port_pkg::PIN_IDLE;
            wr_n <= ata_port_pkg::PIN_IDLE;
            cmd_n <= ata_port_pkg::PIN_IDLE;
            ctl_n <= ata_port_pkg::PIN_IDLE;
            ack_n <= ata_port_pkg::PIN_IDLE;
            doe <= 1'b0;
            dout <= ata_port_pkg::DATA_ZERO;
            pend <= 1'b0;
            push <= 1'b0;
            push_data <= ata_port_pkg::DATA_ZERO;
        end else if (ce_in) begin
            push <= 1'b0;
            case (state)
                ata_port_pkg::ST_IDLE: begin
                    if (take) begin
                        kind <= ata_port_pkg::kind_t'(req_kind_in);
                        chan <= req_chan_in;
                        if (req_kind_in == ata_port_pkg::KIND_UD_RD) begin
                            ack_n <= 1'b0;
                            wr_n <= 1'b0;
                            state <= ata_port_pkg::ST_UD_RD;
                        end else if (req_kind_in == ata_port_pkg::KIND_UD_WR) begin
                            ack_n <= 1'b0;
                            wr_n <= 1'b0;
                            state <= ata_port_pkg::ST_UD_WR;
                        end else begin
                            cnt <= ata_port_pkg::SETUP_CYC;
                            state <= ata_port_pkg::ST_SETUP;
                            if (req_kind_in == ata_port_pkg::KIND_DMA_RD
                                || req_kind_in == ata_port_pkg::KIND_DMA_WR) begin
                                ack_n <= 1'b0;
                            end else if (req_ctl_blk_in) begin
                                ctl_n <= 1'b0;
                            end else begin
                                cmd_n <= 1'b0;
                            end
                            if (req_kind_in == ata_port_pkg::KIND_REG_WR
                                || req_kind_in == ata_port_pkg::KIND_DMA_WR) begin
                                dout <= req_wdata_in;
                                doe <= 1'b1;
                            end
                        end
                    end
                end
                ata_port_pkg::ST_SETUP: begin
                    if (cnt == ata_port_pkg::CNT_LAST) begin
                        cnt <= ata_port_pkg::STROBE_CYC;
                        state <= ata_port_pkg::ST_STROBE;
                        if (is_wr) begin
                            wr_n <= 1'b0;
                        end else begin
                            rd_n <= 1'b0;
                        end
                    end else begin
                        cnt <= cnt - ata_port_pkg::CNT_LAST;
                    end
                end
                ata_port_pkg::ST_STROBE: begin
                    // Strobe stretches while the drive holds ready low
                    if (cnt == ata_port_pkg::CNT_LAST && rdy) begin
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        cnt <= ata_port_pkg::RECOV_CYC;
                        state <= ata_port_pkg::ST_RECOV;
                        if (!is_wr) begin
                            push <= 1'b1;
                            push_data <= din;
                        end
                    end else if (cnt != ata_port_pkg::CNT_LAST) begin
                        cnt <= cnt - ata_port_pkg::CNT_LAST;
                    end
                end
                ata_port_pkg::ST_RECOV: begin
                    if (cnt == ata_port_pkg::CNT_LAST) begin
                        cmd_n <= 1'b1;
                        ctl_n <= 1'b1;
                        ack_n <= 1'b1;
                        doe <= 1'b0;
                        state <= ata_port_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt - ata_port_pkg::CNT_LAST;
                    end
                end
                ata_port_pkg::ST_UD_RD: begin
                    // Pause decided a cycle late; drive must honour pause
                    rd_n <= !buf_in_ready;
                    if (rdy_edge) begin
                        push <= 1'b1;
                        push_data <= din;
                    end
                    if (udma_stop_in || !dreq) begin
                        wr_n <= 1'b1;
                        rd_n <= 1'b1;
                        state <= ata_port_pkg::ST_UD_STOP;
                    end
                end
                ata_port_pkg::ST_UD_WR: begin
                    if (pend) begin
                        rd_n <= ~rd_n;
                        pend <= 1'b0;
                    end else if (req_valid_in && req_ready_out) begin
                        dout <= req_wdata_in;
                        doe <= 1'b1;
                        pend <= 1'b1;
                    end else if (udma_stop_in || !dreq) begin
                        wr_n <= 1'b1;
                        state <= ata_port_pkg::ST_UD_STOP;
                    end
                end
                ata_port_pkg::ST_UD_STOP: begin
                    if (!dreq) begin
                        ack_n <= 1'b1;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        doe <= 1'b0;
                        state <= ata_port_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ata_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Address lines float until reset is released
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            addr_oe <= 1'b0;
        end else begin
            addr_oe <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Read word buffer
    // ----------------------------------------------------------------
    word_buffer u_rd_buf (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_n),
        .ce_in(ce_in),
        .in_valid_in(push),
        .in_data_in(push_data),
        .in_ready_out(buf_in_ready),
        .out_valid_out(rd_valid_out),
        .out_ready_in(rd_ready_in),
        .out_data_out(rd_data_out)
    );

    // ----------------------------------------------------------------
    // Pin mapping, idle connector held inactive
    // ----------------------------------------------------------------
    assign pri_reg_addr_out = addr_q[0];
    assign sec_reg_addr_out = addr_q[1];
    assign pri_reg_addr_oe_out = addr_oe;
    assign sec_reg_addr_oe_out = addr_oe;
    assign pri_cmd_block_sel_n_out = cmd_n | chan;
    assign sec_cmd_block_sel_n_out = cmd_n | ~chan;
    assign pri_ctl_block_sel_n_out = ctl_n | chan;
    assign sec_ctl_block_sel_n_out = ctl_n | ~chan;
    assign sec_ctl_block_sel_oe_out = !pos_in;
    assign pri_dma_ack_n_out = ack_n | chan;
    assign sec_dma_ack_n_out = ack_n | ~chan;
    assign pri_read_strobe_n_out = rd_n | chan;
    assign sec_read_strobe_n_out = rd_n | ~chan;
    assign pri_write_strobe_n_out = wr_n | chan;
    assign sec_write_strobe_n_out = wr_n | ~chan;
    assign pri_write_strobe_oe_out = !pos_in;
    assign pri_disk_data_out = dout;
    assign sec_disk_data_out = dout;
    assign pri_disk_data_oe_out = doe & ~chan;
    assign sec_disk_data_oe_out = doe & chan;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    sequence pio_strobe_end_s;
        ce_in && st_strobe && cnt == ata_port_pkg::CNT_LAST && rdy;
    endsequence

    sequence reg_take_s;
        ce_in && take && req_kind_in == ata_port_pkg::KIND_REG_RD;
    endsequence

    addr_drive_a: assert property (
        ce_in && take && !req_chan_in |=> pri_reg_addr_out == $past(req_addr_in))
        else $error("address not driven");
    cmd_select_a: assert property (
        reg_take_s ##0 !req_ctl_blk_in |=> !cmd_n && ctl_n && ack_n)
        else $error("command select wrong");
    ctl_select_a: assert property (
        reg_take_s ##0 req_ctl_blk_in |=> !ctl_n && cmd_n && ack_n)
        else $error("control select wrong");
    data_release_a: assert property (
        doe |-> is_wr || kind == ata_port_pkg::KIND_UD_WR)
        else $error("data driven outside write");
    ack_exclusive_a: assert property (
        !ack_n |-> cmd_n && ctl_n && (is_dma || !st_strobe))
        else $error("ack with select");
    read_capture_a: assert property (
        pio_strobe_end_s ##0 !is_wr |=> push && push_data == $past(din) && rd_n)
        else $error("read word not captured");
    write_hold_a: assert property (
        st_strobe && is_wr |-> doe && !wr_n && rd_n)
        else $error("write strobe without data");
    ready_wait_a: assert property (
        ce_in && st_strobe && cnt == ata_port_pkg::CNT_LAST && !rdy |=> st_strobe && !(rd_n && wr_n))
        else $error("strobe ended while not ready");
    ud_pause_a: assert property (
        ce_in && st_ud_rd && !buf_in_ready |=> rd_n)
        else $error("no pause on full buffer");
    ud_toggle_a: assert property (
        ce_in && st_ud_wr && pend |=> rd_n != $past(rd_n) && !pend)
        else $error("strobe did not toggle");
    ud_capture_a: assert property (
        ce_in && st_ud_rd && rdy_edge |=> push)
        else $error("sync read word missed");
    ud_stop_a: assert property (
        state == ata_port_pkg::ST_UD_STOP |-> wr_n && !ack_n)
        else $error("stop not asserted");
    idle_pins_a: assert property (
        st_idle |-> rd_n && wr_n && cmd_n && ctl_n && ack_n && !doe)
        else $error("idle pins not high");

endmodule : ata_host_channel_port

// >>> hdl/ata_port_pkg.sv
// Purpose: shared constants and types for the disk channel host port
// Assumes: 40 MHz ref_clk_in, one transfer in flight at a time
// Notes: timing figures are register-cycle minimums, rounded up to cycles

package ata_port_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int T_SETUP_NS = 70;
    localparam int T_STROBE_NS = 165;
    localparam int T_RECOV_NS = 70;
    localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RECOV_CYC = 4'((T_RECOV_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_LAST = 4'h1;

    // ----------------------------------------------------------------
    // Widths and idle values
    // ----------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int NCHAN = 2;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 3'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_REG_RD = 3'h0,
        KIND_REG_WR = 3'h1,
        KIND_DMA_RD = 3'h2,
        KIND_DMA_WR = 3'h3,
        KIND_UD_RD = 3'h4,
        KIND_UD_WR = 3'h5
    } kind_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_STROBE = 7'h04,
        ST_RECOV = 7'h08,
        ST_UD_RD = 7'h10,
        ST_UD_WR = 7'h20,
        ST_UD_STOP = 7'h40
    } state_t;

endpackage : ata_port_pkg

// >>> hdl/word_buffer.sv
// Purpose: two-entry word buffer between disk read capture and user side
// Assumes: same clock domain on both sides
// Notes: freezes with ce_in low

`timescale 1ns/100ps

module word_buffer (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    input wire logic [ata_port_pkg::DATA_W-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [ata_port_pkg::DATA_W-1:0] out_data_out
);

    logic [ata_port_pkg::DATA_W-1:0] mem [ata_port_pkg::BUF_DEPTH];
    logic wr_idx;
    logic rd_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != ata_port_pkg::BUF_FULL);
    assign out_valid_out = (count != ata_port_pkg::BUF_EMPTY);
    assign push = ce_in && in_valid_in && in_ready_out;
    assign pop = ce_in && out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_idx];

    // ----------------------------------------------------------------
    // Storage, no reset needed on data
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_idx] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count <= ata_port_pkg::BUF_EMPTY;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end

endmodule : word_buffer

// >>> test/disk_model.sv
// Purpose: drive model on the primary connector
// Assumes: register and DMA strobe cycles only
// Notes: a released bus shows the inverse of the last word
`timescale 1ns/100ps
module disk_model (
    input wire logic [2:0] addr_in,
    input wire logic cmd_n_in,
    input wire logic ctl_n_in,
    input wire logic ack_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic [15:0] cap_data_out,
    output logic [2:0] cap_addr_out,
    output logic cap_ctl_out
);
    logic sel;
    logic [15:0] word;
    logic [15:0] last = 16'h0000;
    assign sel = !cmd_n_in || !ctl_n_in || !ack_n_in;
    assign word = ack_n_in ? {13'h0B40, addr_in} : 16'hD3A7;
    assign dq_out = (sel && !rd_n_in) ? word : ~last;
    always @(posedge rd_n_in) last <= word;
    always @(posedge wr_n_in) begin
        if (sel) begin
            cap_data_out <= dq_in;
            cap_addr_out <= addr_in;
            cap_ctl_out <= !ctl_n_in;
        end
    end
endmodule : disk_model

// >>> test/tb_ata_host_channel_port.sv
// Purpose: bench for the primary connector of the host port
// Assumes: drive model on the primary pins only
// Notes: secondary inputs held idle
`timescale 1ns/100ps
module tb_ata_host_channel_port;
    logic ref_clk_in, rst_b_in, ce_in, pos_in, single_chan_in, req_valid_in, req_chan_in;
    logic req_ctl_blk_in, udma_stop_in, rd_ready_in, pri_dma_req_in, pri_chan_ready_in;
    logic sec_dma_req_in, sec_chan_ready_in, req_ready_out, rd_valid_out, busy_out;
    logic pri_reg_addr_oe_out, pri_cmd_block_sel_n_out, pri_ctl_block_sel_n_out;
    logic pri_disk_data_oe_out, pri_dma_ack_n_out, pri_read_strobe_n_out;
    logic pri_write_strobe_n_out, pri_write_strobe_oe_out, sec_reg_addr_oe_out;
    logic sec_cmd_block_sel_n_out, sec_ctl_block_sel_n_out, sec_ctl_block_sel_oe_out;
    logic sec_disk_data_oe_out, sec_dma_ack_n_out, sec_read_strobe_n_out, sec_write_strobe_n_out;
    logic [2:0] req_kind_in, req_addr_in, pri_reg_addr_out, sec_reg_addr_out, cap_a;
    logic [15:0] req_wdata_in, rd_data_out, pri_disk_data_in, pri_disk_data_out, dq, cap_d;
    logic [15:0] sec_disk_data_in, sec_disk_data_out;
    logic cap_c;
    int n_errors = 0;
    int checked = 0;
    ata_host_channel_port i_dut (.*);
    disk_model i_drive (.addr_in(pri_reg_addr_out), .cmd_n_in(pri_cmd_block_sel_n_out),
        .ctl_n_in(pri_ctl_block_sel_n_out), .ack_n_in(pri_dma_ack_n_out),
        .rd_n_in(pri_read_strobe_n_out), .wr_n_in(pri_write_strobe_n_out),
        .dq_in(pri_disk_data_in), .dq_out(dq), .cap_data_out(cap_d), .cap_addr_out(cap_a),
        .cap_ctl_out(cap_c));
    assign pri_disk_data_in = pri_disk_data_oe_out ? pri_disk_data_out : dq;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic req(input logic [2:0] k, input logic c, input logic [2:0] a);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        {req_valid_in, req_kind_in, req_ctl_blk_in, req_addr_in} <= {1'b1, k, c, a};
        req_wdata_in <= 16'hC3E1;
        do @(negedge ref_clk_in); while (req_ready_out !== 1'b1 && ++n < 99);
        @(posedge ref_clk_in);
        req_valid_in <= 1'b0;
        n = 0;
        do @(negedge ref_clk_in); while (busy_out !== 1'b0 && ++n < 99);
    endtask : req
    task automatic pull(input logic [15:0] e);
        int n;
        n = 0;
        do @(negedge ref_clk_in); while (rd_valid_out !== 1'b1 && ++n < 30);
        chk("rd_data", e, rd_data_out);
        @(posedge ref_clk_in);
        rd_ready_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_ready_in <= 1'b0;
    endtask : pull
    task automatic end_of_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial begin
        ref_clk_in = 0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #100us;
        n_errors++;
        end_of_test();
    end
    initial begin
        {rst_b_in, pos_in, single_chan_in, req_valid_in, req_chan_in, udma_stop_in} = 0;
        {rd_ready_in, pri_dma_req_in, sec_dma_req_in, req_ctl_blk_in} = 0;
        {ce_in, pri_chan_ready_in, sec_chan_ready_in} = 3'h7;
        {req_kind_in, req_addr_in, req_wdata_in, sec_disk_data_in} = 0;
        repeat (8) @(posedge ref_clk_in);
        chk("reset_oe", 16'h0000, {pri_disk_data_oe_out, pri_reg_addr_oe_out});
        chk("reset_sel", 16'h000F, {pri_cmd_block_sel_n_out, pri_ctl_block_sel_n_out,
            pri_dma_ack_n_out, pri_read_strobe_n_out});
        rst_b_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        pos_in <= 1'b1;
        @(negedge ref_clk_in);
        chk("pos_float", 16'h0000, {pri_write_strobe_oe_out, sec_ctl_block_sel_oe_out});
        pos_in <= 1'b0;
        $display("test idle_pins done");
        req(3'h1, 1'b0, 3'h5);
        chk("wr_data", 16'hC3E1, cap_d);
        chk("wr_addr", 16'h0005, {13'h0000, cap_a});
        chk("wr_block", 16'h0000, {15'h0000, cap_c});
        chk("wr_release", 16'h0000, {15'h0000, pri_disk_data_oe_out});
        $display("test reg_write done");
        req(3'h0, 1'b1, 3'h3);
        req(3'h0, 1'b1, 3'h6);
        chk("full_refused", 16'h0000, {15'h0000, req_ready_out});
        pull(16'h5A03);
        pull(16'h5A06);
        $display("test buffer_fill done");
        pri_dma_req_in <= 1'b1;
        req(3'h2, 1'b0, 3'h0);
        pull(16'hD3A7);
        pri_dma_req_in <= 1'b0;
        $display("test dma_read done");
        single_chan_in <= 1'b1;
        req(3'h1, 1'b0, 3'h2);
        chk("slave_addr", 16'h0002, {13'h0000, sec_reg_addr_out});
        $display("test single_chan done");
        end_of_test();
    end
endmodule : tb_ata_host_channel_port
